// ==== src/byte_fifo.sv ====
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         mclk_i,
  input  wire logic         resetn_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_r != (AW+1)'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rd_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (flush_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== src/serial_device_end.sv ====
`timescale 1ns/1ps
`include "serial_port_defines.svh"
module serial_device_end (
  input  wire logic                 mclk_i,
  input  wire logic                 resetn_i,
  serial_link_if.dev                link,
  input  wire logic                 sleep_i,
  output logic                      rx_valid_o,
  input  wire logic                 rx_ready_i,
  output logic [`DATA_W-1:0]        rx_data_o,
  input  wire logic                 tx_valid_i,
  output logic                      tx_ready_o,
  input  wire logic [`DATA_W-1:0]   tx_data_i,
  output logic                      ready_n_o,
  output logic                      standby_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] rxd_q;
  logic [1:0] bd_q;
  logic [1:0] stb_q;
  logic [2:0] sel_q0;
  logic [2:0] sel_q1;
  logic       bd_d;
  logic       rxd_s;
  logic       bd_s;
  logic       stb_s;

  assign rxd_s = rxd_q[1];
  assign bd_s  = bd_q[1];
  assign stb_s = stb_q[1];

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rxd_q  <= 2'h3;
      bd_q   <= 2'h3;
      stb_q  <= 2'h3;
      sel_q0 <= 3'h7;
      sel_q1 <= 3'h7;
      bd_d   <= 1'h1;
    end else begin
      rxd_q  <= {rxd_q[0], link.rxd};
      bd_q   <= {bd_q[0], link.baud_detect_in};
      stb_q  <= {stb_q[0], link.standby_n};
      sel_q0 <= link.baud_select;
      sel_q1 <= sel_q0;
      bd_d   <= bd_s;
    end
  end

  // ----------------------------------------
  // standby and sleep
  // ----------------------------------------
  serial_port_pkg::pwr_state_t pwr_r;
  logic [15:0]                 wake_r;
  logic                        halted;

  assign halted    = (pwr_r != serial_port_pkg::PWR_ACTIVE);
  assign standby_o = halted;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_r  <= serial_port_pkg::PWR_ACTIVE;
      wake_r <= '0;
    end else begin
      unique case (pwr_r)
        serial_port_pkg::PWR_ACTIVE: begin
          wake_r <= '0;
          if (!stb_s) begin
            pwr_r <= serial_port_pkg::PWR_STANDBY;
          end else if (sleep_i) begin
            pwr_r <= serial_port_pkg::PWR_SLEEP;
          end
        end
        serial_port_pkg::PWR_STANDBY: begin
          if (stb_s) begin
            pwr_r <= serial_port_pkg::PWR_ACTIVE;
          end
        end
        serial_port_pkg::PWR_SLEEP: begin
          // a short glitch must not wake, so the low time is measured first
          if (!stb_s) begin
            if (wake_r != 16'(`WAKE_MIN_CYC)) begin
              wake_r <= wake_r + 16'h1;
            end
          end else if (wake_r == 16'(`WAKE_MIN_CYC)) begin
            pwr_r <= serial_port_pkg::PWR_ACTIVE;
          end else begin
            wake_r <= '0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // baud rate selection and detection
  // ----------------------------------------
  logic        auto_mode;
  logic [15:0] low_r;
  logic [15:0] det_r;
  logic [15:0] bit_cyc;

  assign auto_mode = (sel_q1 == `BAUD_AUTO_SEL);
  assign bit_cyc   = auto_mode ? det_r : serial_port_pkg::bit_cycles(sel_q1);

  // keeps the shortest low pulse below the 9600-baud start value, which is one bit time once
  // a character with an isolated zero bit has gone by at 9600 baud or faster
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_r <= '0;
      det_r <= 16'(`BIT_CYC_DEFAULT);
    end else if (halted || !auto_mode) begin
      low_r <= '0;
      det_r <= 16'(`BIT_CYC_DEFAULT);
    end else begin
      if (!bd_s) begin
        low_r <= (low_r == 16'hffff) ? low_r : low_r + 16'h1;
      end else begin
        low_r <= '0;
      end
      if (bd_s && !bd_d && low_r >= 16'(`AUTO_MIN_CYC) && low_r < det_r) begin
        det_r <= low_r;
      end
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  serial_port_pkg::rx_state_t rx_r;
  logic [15:0]                rcnt_r;
  logic [2:0]                 rbit_r;
  logic [`DATA_W-1:0]         rsh_r;
  logic                       rpush_r;
  logic                       fifo_in_ready;
  logic [7:0]                 ack_r;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_r    <= serial_port_pkg::RX_IDLE;
      rcnt_r  <= '0;
      rbit_r  <= '0;
      rsh_r   <= '0;
      rpush_r <= 1'h0;
    end else if (halted) begin
      rx_r    <= serial_port_pkg::RX_IDLE;
      rpush_r <= 1'h0;
    end else begin
      rpush_r <= 1'h0;
      if (rcnt_r != '0) begin
        rcnt_r <= rcnt_r - 16'h1;
      end
      unique case (rx_r)
        serial_port_pkg::RX_IDLE: begin
          if (!rxd_s) begin
            rx_r   <= serial_port_pkg::RX_START;
            rcnt_r <= {1'b0, bit_cyc[15:1]};
          end
        end
        serial_port_pkg::RX_START: begin
          if (rcnt_r == '0) begin
            rx_r   <= rxd_s ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
            rcnt_r <= bit_cyc - 16'h1;
            rbit_r <= '0;
          end
        end
        serial_port_pkg::RX_DATA: begin
          if (rcnt_r == '0) begin
            rsh_r  <= {rxd_s, rsh_r[`DATA_W-1:1]};
            rbit_r <= rbit_r + 3'h1;
            rcnt_r <= bit_cyc - 16'h1;
            if (rbit_r == 3'h7) begin
              rx_r <= serial_port_pkg::RX_STOP;
            end
          end
        end
        serial_port_pkg::RX_STOP: begin
          if (rcnt_r == '0) begin
            rpush_r <= rxd_s;
            rx_r    <= serial_port_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // a byte sent against a high clear-to-send is dropped when full
  byte_fifo #(
    .W (`DATA_W),
    .D (`FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .flush_i     (halted),
    .in_valid_i  (rpush_r),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rsh_r),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_r <= '0;
    end else if (rpush_r && !halted) begin
      ack_r <= 8'(`ACK_CYC);
    end else if (ack_r != '0) begin
      ack_r <= ack_r - 8'h1;
    end
  end

  assign link.cts_n = halted | (ack_r != '0) | !fifo_in_ready;
  assign ready_n_o  = halted | (ack_r != '0) | !fifo_in_ready;

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  serial_port_pkg::tx_state_t tx_r;
  logic [15:0]                tcnt_r;
  logic [3:0]                 tbit_r;
  logic [`FRAME_BITS-1:0]     tsh_r;
  logic                       txd_r;

  assign tx_ready_o = (tx_r == serial_port_pkg::TX_IDLE) & !halted;
  assign link.txd   = txd_r;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_r   <= serial_port_pkg::TX_IDLE;
      tcnt_r <= '0;
      tbit_r <= '0;
      tsh_r  <= '1;
      txd_r  <= 1'h1;
    end else if (halted) begin
      tx_r  <= serial_port_pkg::TX_IDLE;
      txd_r <= 1'h1;
    end else begin
      unique case (tx_r)
        serial_port_pkg::TX_IDLE: begin
          if (tx_valid_i) begin
            tsh_r  <= {1'b1, tx_data_i, 1'b0};
            txd_r  <= 1'h0;
            tcnt_r <= bit_cyc - 16'h1;
            tbit_r <= '0;
            tx_r   <= serial_port_pkg::TX_SEND;
          end
        end
        serial_port_pkg::TX_SEND: begin
          if (tcnt_r != '0) begin
            tcnt_r <= tcnt_r - 16'h1;
          end else if (tbit_r == 4'(`FRAME_BITS - 1)) begin
            tx_r  <= serial_port_pkg::TX_IDLE;
            txd_r <= 1'h1;
          end else begin
            tsh_r  <= {1'b1, tsh_r[`FRAME_BITS-1:1]};
            txd_r  <= tsh_r[1];
            tbit_r <= tbit_r + 4'h1;
            tcnt_r <= bit_cyc - 16'h1;
          end
        end
      endcase
    end
  end
endmodule

// ==== src/serial_host_end.sv ====
`timescale 1ns/1ps
`include "serial_port_defines.svh"
module serial_host_end (
  input  wire logic               mclk_i,
  input  wire logic               resetn_i,
  serial_link_if.host             link,
  input  wire logic [2:0]         baud_sel_i,
  input  wire logic               standby_req_i,
  input  wire logic               wake_i,
  input  wire logic               tx_valid_i,
  output logic                    tx_ready_o,
  input  wire logic [`DATA_W-1:0] tx_data_i,
  output logic                    rx_valid_o,
  output logic [`DATA_W-1:0]      rx_data_o
);
  // ----------------------------------------
  // static pins and standby drive
  // ----------------------------------------
  logic [1:0]  cts_q;
  logic [1:0]  txd_q;
  logic [15:0] wake_r;
  logic [15:0] bit_cyc;

  assign link.baud_select         = baud_sel_i;
  assign link.channel_pair_select = 5'h0;
  assign link.analog_clear_n      = resetn_i;
  // standby high from reset on, so defaults are never restored by accident
  assign link.standby_n = !standby_req_i & (wake_r == '0);
  // auto mode falls back to the detector's power-up rate
  assign bit_cyc = serial_port_pkg::bit_cycles(baud_sel_i);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cts_q  <= 2'h3;
      txd_q  <= 2'h3;
      wake_r <= '0;
    end else begin
      cts_q <= {cts_q[0], link.cts_n};
      txd_q <= {txd_q[0], link.txd};
      if (wake_r != '0) begin
        wake_r <= wake_r - 16'h1;
      end else if (wake_i) begin
        wake_r <= 16'(`WAKE_MIN_CYC + 1);
      end
    end
  end

  // ----------------------------------------
  // transmitter, paced by clear-to-send
  // ----------------------------------------
  serial_port_pkg::tx_state_t tx_r;
  logic [15:0]                tcnt_r;
  logic [3:0]                 tbit_r;
  logic [`FRAME_BITS-1:0]     tsh_r;
  logic                       rxd_r;

  assign tx_ready_o = (tx_r == serial_port_pkg::TX_IDLE) & !cts_q[1];
  assign link.rxd   = rxd_r;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_r   <= serial_port_pkg::TX_IDLE;
      tcnt_r <= '0;
      tbit_r <= '0;
      tsh_r  <= '1;
      rxd_r  <= 1'h1;
    end else begin
      unique case (tx_r)
        serial_port_pkg::TX_IDLE: begin
          if (tx_valid_i && !cts_q[1]) begin
            tsh_r  <= {1'b1, tx_data_i, 1'b0};
            rxd_r  <= 1'h0;
            tcnt_r <= bit_cyc - 16'h1;
            tbit_r <= '0;
            tx_r   <= serial_port_pkg::TX_SEND;
          end
        end
        serial_port_pkg::TX_SEND: begin
          if (tcnt_r != '0) begin
            tcnt_r <= tcnt_r - 16'h1;
          end else if (tbit_r == 4'(`FRAME_BITS - 1)) begin
            tx_r  <= serial_port_pkg::TX_IDLE;
            rxd_r <= 1'h1;
          end else begin
            tsh_r  <= {1'b1, tsh_r[`FRAME_BITS-1:1]};
            rxd_r  <= tsh_r[1];
            tbit_r <= tbit_r + 4'h1;
            tcnt_r <= bit_cyc - 16'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  serial_port_pkg::rx_state_t rx_r;
  logic [15:0]                rcnt_r;
  logic [2:0]                 rbit_r;
  logic [`DATA_W-1:0]         rsh_r;
  logic                       rv_r;

  assign rx_valid_o = rv_r;
  assign rx_data_o  = rsh_r;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_r   <= serial_port_pkg::RX_IDLE;
      rcnt_r <= '0;
      rbit_r <= '0;
      rsh_r  <= '0;
      rv_r   <= 1'h0;
    end else begin
      rv_r <= 1'h0;
      if (rcnt_r != '0) begin
        rcnt_r <= rcnt_r - 16'h1;
      end
      unique case (rx_r)
        serial_port_pkg::RX_IDLE: begin
          if (!txd_q[1]) begin
            rx_r   <= serial_port_pkg::RX_START;
            rcnt_r <= {1'b0, bit_cyc[15:1]};
          end
        end
        serial_port_pkg::RX_START: begin
          if (rcnt_r == '0) begin
            rx_r   <= txd_q[1] ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
            rcnt_r <= bit_cyc - 16'h1;
            rbit_r <= '0;
          end
        end
        serial_port_pkg::RX_DATA: begin
          if (rcnt_r == '0) begin
            rsh_r  <= {txd_q[1], rsh_r[`DATA_W-1:1]};
            rbit_r <= rbit_r + 3'h1;
            rcnt_r <= bit_cyc - 16'h1;
            if (rbit_r == 3'h7) begin
              rx_r <= serial_port_pkg::RX_STOP;
            end
          end
        end
        serial_port_pkg::RX_STOP: begin
          if (rcnt_r == '0) begin
            rv_r <= txd_q[1];
            rx_r <= serial_port_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ==== src/serial_link_if.sv ====
`timescale 1ns/1ps
interface serial_link_if;
  logic       rxd;
  logic       txd;
  logic       cts_n;
  logic       baud_detect_in;
  logic [2:0] baud_select;
  logic       standby_n;
  logic [4:0] channel_pair_select;
  logic       analog_clear_n;
  // detect input strapped to the receive line, the usual board wiring
  assign baud_detect_in = rxd;
  modport dev (
    input  rxd,
    input  baud_detect_in,
    input  baud_select,
    input  standby_n,
    input  channel_pair_select,
    input  analog_clear_n,
    output txd,
    output cts_n
  );
  modport host (
    output rxd,
    output baud_select,
    output standby_n,
    output channel_pair_select,
    output analog_clear_n,
    input  txd,
    input  cts_n
  );
endinterface

// ==== src/serial_port_defines.svh ====
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH
// ----------------------------------------
// clock
// ----------------------------------------
`define CLK_HZ           20000000
`define CLK_PERIOD_NS    50
// ----------------------------------------
// baud table, index is the baud_select code
// ----------------------------------------
`define BAUD_0           115200
`define BAUD_1           57600
`define BAUD_2           38400
`define BAUD_3           19200
`define BAUD_4           14400
`define BAUD_5           9600
`define BAUD_6           7200
`define BAUD_AUTO_SEL    3'h7
`define BAUD_DEFAULT     `BAUD_5
`define BIT_CYC_0        (`CLK_HZ / `BAUD_0)
`define BIT_CYC_1        (`CLK_HZ / `BAUD_1)
`define BIT_CYC_2        (`CLK_HZ / `BAUD_2)
`define BIT_CYC_3        (`CLK_HZ / `BAUD_3)
`define BIT_CYC_4        (`CLK_HZ / `BAUD_4)
`define BIT_CYC_5        (`CLK_HZ / `BAUD_5)
`define BIT_CYC_6        (`CLK_HZ / `BAUD_6)
`define BIT_CYC_DEFAULT  (`CLK_HZ / `BAUD_DEFAULT)
// shortest low pulse accepted as one bit by the detector
`define AUTO_MIN_CYC     (`BIT_CYC_0 / 2)
// ----------------------------------------
// framing and buffer
// ----------------------------------------
`define DATA_W           8
`define FIFO_DEPTH       32
`define FRAME_BITS       10
// ----------------------------------------
// timing
// ----------------------------------------
`define ACK_NS           2000
`define ACK_CYC          ((`ACK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_MIN_NS      10000
`define WAKE_MIN_CYC     ((`WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_HOLD_MS    1
`define PINS_VALID_MS    2
`define STANDBY_N_HIGH_MS     500
`endif

// ==== src/serial_port_pkg.sv ====
`include "serial_port_defines.svh"
package serial_port_pkg;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_SEND = 2'h2
  } tx_state_t;
  typedef enum logic [2:0] {
    PWR_ACTIVE  = 3'h1,
    PWR_STANDBY = 3'h2,
    PWR_SLEEP   = 3'h4
  } pwr_state_t;
  function automatic logic [15:0] bit_cycles(input logic [2:0] sel);
    case (sel)
      3'h0:    return 16'(`BIT_CYC_0);
      3'h1:    return 16'(`BIT_CYC_1);
      3'h2:    return 16'(`BIT_CYC_2);
      3'h3:    return 16'(`BIT_CYC_3);
      3'h4:    return 16'(`BIT_CYC_4);
      3'h5:    return 16'(`BIT_CYC_5);
      3'h6:    return 16'(`BIT_CYC_6);
      default: return 16'(`BIT_CYC_DEFAULT);
    endcase
  endfunction
endpackage

// ==== test/serial_host_port_standby_reset_tb.sv ====
`timescale 1ns/1ps
`include "serial_port_defines.svh"
module serial_host_port_standby_reset_tb;
  localparam int BC0 = `CLK_HZ / `BAUD_0;
  logic       mclk = 1'b0;
  logic       resetn = 1'b0;
  logic       sleep = 1'b0;
  logic       d_rx_ready = 1'b0;
  logic       d_tx_valid = 1'b0;
  logic [7:0] d_tx_data = 8'h00;
  logic [2:0] baud_sel = 3'h0;
  logic       standby_n_req = 1'b0;
  logic       wake = 1'b0;
  logic       h_tx_valid = 1'b0;
  logic [7:0] h_tx_data = 8'h00;
  logic       d_rx_valid, d_tx_ready, d_ready_n, d_standby, h_tx_ready, h_rx_valid;
  logic [7:0] d_rx_data, h_rx_data;
  logic [7:0] h_got = 8'h00;
  int         n_fail = 0;
  int         samples_checked = 0;
  serial_link_if link ();
  serial_device_end u_serial_device_end (.mclk_i(mclk), .resetn_i(resetn), .link(link.dev),
    .sleep_i(sleep), .rx_valid_o(d_rx_valid), .rx_ready_i(d_rx_ready), .rx_data_o(d_rx_data),
    .tx_valid_i(d_tx_valid), .tx_ready_o(d_tx_ready), .tx_data_i(d_tx_data),
    .ready_n_o(d_ready_n), .standby_o(d_standby));
  serial_host_end u_serial_host_end (.mclk_i(mclk), .resetn_i(resetn), .link(link.host),
    .baud_sel_i(baud_sel), .standby_req_i(standby_n_req), .wake_i(wake), .tx_valid_i(h_tx_valid),
    .tx_ready_o(h_tx_ready), .tx_data_i(h_tx_data), .rx_valid_o(h_rx_valid),
    .rx_data_o(h_rx_data));
  serial_link_assertions u_serial_link_assertions (.mclk_i(mclk), .resetn_i(resetn),
    .rxd(link.rxd), .txd(link.txd), .cts_n(link.cts_n), .baud_detect_in(link.baud_detect_in),
    .standby_n(link.standby_n), .channel_pair_select(link.channel_pair_select));
  initial begin
    forever #25 mclk = ~mclk;
  end
  // host receive pulse lasts one cycle, so latch it here
  always @(posedge mclk) begin
    if (h_rx_valid === 1'b1) begin
      h_got <= h_rx_data;
    end
  end
  // ------
  // tasks
  // ------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    complete_run();
  endtask
  task automatic host_send(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge mclk);
    h_tx_valid <= 1'b1;
    h_tx_data <= b;
    do begin
      @(negedge mclk);
      n++;
      if (n > 40000) hang();
    end while (h_tx_ready !== 1'b1);
    @(posedge mclk);
    h_tx_valid <= 1'b0;
  endtask
  task automatic dev_pop(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      if (n > 40000) hang();
    end while (d_rx_valid !== 1'b1);
    chk(d_rx_data, exp);
    @(posedge mclk);
    d_rx_ready <= 1'b1;
    @(posedge mclk);
    d_rx_ready <= 1'b0;
  endtask
  // samples the wire at mid-bit; start, data lsb first, stop
  task automatic dev_send(input logic [7:0] b, input int bc);
    int n;
    n = 0;
    @(posedge mclk);
    d_tx_valid <= 1'b1;
    d_tx_data <= b;
    do begin
      @(negedge mclk);
      n++;
      if (n > 1000) hang();
    end while (d_tx_ready !== 1'b1);
    @(posedge mclk);
    d_tx_valid <= 1'b0;
    repeat (bc / 2) @(negedge mclk);
    chk({7'h00, link.txd}, 8'h00);
    for (int i = 0; i < 9; i++) begin
      repeat (bc) @(negedge mclk);
      chk({7'h00, link.txd}, (i < 8) ? {7'h00, b[i]} : 8'h01);
    end
  endtask
  // ------
  // main sequence
  // ------
  initial begin
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    chk({6'h00, link.cts_n, link.txd}, 8'h01);
    chk({7'h00, d_standby}, 8'h00);
    @(posedge mclk);
    resetn <= 1'b1;
    host_send(8'ha5);
    dev_pop(8'ha5);
    dev_send(8'h3c, BC0);
    repeat (BC0) @(negedge mclk);
    chk(h_got, 8'h3c);
    for (int i = 0; i < 32; i++) begin
      host_send(8'(i));
    end
    repeat (2000) @(negedge mclk);
    chk({7'h00, link.cts_n}, 8'h01);
    dev_pop(8'h00);
    repeat (10) @(negedge mclk);
    chk({7'h00, link.cts_n}, 8'h00);
    for (int i = 1; i < 32; i++) begin
      dev_pop(8'(i));
    end
    host_send(8'h77);
    repeat (2000) @(negedge mclk);
    chk({7'h00, d_rx_valid}, 8'h01);
    // a frame of zeros is cut off in its first data bit, after the start bit
    @(posedge mclk);
    d_tx_data <= 8'h00;
    d_tx_valid <= 1'b1;
    repeat (260) @(negedge mclk);
    @(posedge mclk);
    standby_n_req <= 1'b1;
    repeat (10) @(negedge mclk);
    chk({5'h00, d_standby, d_ready_n, link.cts_n}, 8'h07);
    chk({5'h00, d_rx_valid, d_tx_ready, link.txd}, 8'h01);
    repeat (300) @(negedge mclk);
    chk({7'h00, link.txd}, 8'h01);
    @(posedge mclk);
    standby_n_req <= 1'b0;
    d_tx_valid <= 1'b0;
    repeat (10) @(negedge mclk);
    chk({5'h00, d_standby, link.cts_n, d_rx_valid}, 8'h00);
    @(posedge mclk);
    sleep <= 1'b1;
    @(posedge mclk);
    sleep <= 1'b0;
    repeat (5) @(negedge mclk);
    chk({6'h00, d_standby, link.cts_n}, 8'h03);
    @(posedge mclk);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    repeat (150) @(negedge mclk);
    chk({7'h00, d_standby}, 8'h01);
    repeat (80) @(negedge mclk);
    chk({6'h00, d_standby, link.cts_n}, 8'h00);
    @(posedge mclk);
    sleep <= 1'b1;
    @(posedge mclk);
    sleep <= 1'b0;
    @(negedge mclk);
    chk({7'h00, d_standby}, 8'h01);
    @(posedge mclk);
    resetn <= 1'b0;
    @(negedge mclk);
    chk({6'h00, d_standby, link.cts_n}, 8'h00);
    @(posedge mclk);
    resetn <= 1'b1;
    baud_sel <= 3'h7;
    host_send(8'h55);
    dev_pop(8'h55);
    complete_run();
  end
endmodule

// ==== test/serial_link_assertions.sv ====
`timescale 1ns/1ps
module serial_link_assertions (
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic       rxd,
  input  wire logic       txd,
  input  wire logic       cts_n,
  input  wire logic       baud_detect_in,
  input  wire logic       standby_n,
  input  wire logic [4:0] channel_pair_select
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // ------
  // helper counters
  // ------
  logic [14:0] low_run_r;
  logic [7:0]  standby_n_low_r;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_run_r <= '0;
    end else if (txd) begin
      low_run_r <= '0;
    end else begin
      low_run_r <= low_run_r + 15'h1;
    end
  end
  // saturates so a long standby never wraps back under the wake minimum
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      standby_n_low_r <= '0;
    end else if (standby_n) begin
      standby_n_low_r <= '0;
    end else if (standby_n_low_r != 8'hff) begin
      standby_n_low_r <= standby_n_low_r + 8'h1;
    end
  end
  // ------
  // properties
  // ------
  // five samples cover the two-flop sync plus the state update
  sequence standby_n_held;
    !standby_n [*5];
  endsequence
  a_detect_tracks_rx: assert property (baud_detect_in == rxd)
    else $error("detect input differs from receive line");
  a_select_held_low: assert property (channel_pair_select == 5'h00)
    else $error("channel select not low");
  a_standby_cts_high: assert property (standby_n_held |-> cts_n)
    else $error("clear-to-send low in standby");
  a_standby_txd_idle: assert property (standby_n_held |-> txd)
    else $error("transmit line active in standby");
  a_tx_start_width: assert property ($fell(txd) |-> !txd [*8])
    else $error("transmit start bit too short");
  a_rx_start_width: assert property ($fell(rxd) |-> !rxd [*8])
    else $error("receive start bit too short");
  a_ack_pulse_len: assert property ($rose(cts_n) && standby_n |-> cts_n [*8])
    else $error("acknowledge pulse too short");
  a_tx_low_bounded: assert property (low_run_r <= 15'h61a1)
    else $error("transmit line low beyond nine bits");
  a_wake_pulse_width: assert property ($rose(standby_n) |-> standby_n_low_r >= 8'hc8)
    else $error("standby low pulse too short");
  a_resume_cts_low: assert property ($rose(standby_n) |-> ##[1:8] !cts_n)
    else $error("clear-to-send not restored after standby");
endmodule
